/* File: rtl/sild_consts.svh */
`ifndef SILD_CONSTS_SVH
`define SILD_CONSTS_SVH

// ==========================================================
// widths and timing
`define SILD_WIDTH        8
`define SILD_MSB          7
`define SILD_ZERO8        8'h00
`define SILD_ALL_OFF      8'h00
`define SILD_CLK_NS       10
`define SILD_STB_GAP_NS   300
`define SILD_STB_GAP_CYC  ((`SILD_STB_GAP_NS+`SILD_CLK_NS-1)/`SILD_CLK_NS)

`endif

/* File: rtl/sild_driver.sv */
`timescale 1ns/100ps
`include "sild_consts.svh"
// Overview of operation
// - rising serial clock samples data into stage one
// - later rising edges shift toward serial output
// - strobe high copies stages into latches
// - latches stay transparent while strobe high
// - disable high turns drivers off only
// - disable low drives outputs from latches
// - last stage drives chained serial output
module sild_driver
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 srst,
   // controller side
   input  wire sild_pkg::sild_ctrl_s ctrl,
   // driver, chain and latch outputs
   output      sild_pkg::sild_byte_t drive_on,
   output      logic                 serial_out,
   output      sild_pkg::sild_byte_t latch_view
);

   sild_pkg::sild_state_s state;
   sild_pkg::sild_state_s next_state;
   logic                  sclk_rise;

   // rising level seen against the previous sample
   function automatic logic rise_of
   (
      input logic now_lvl,
      input logic was_lvl
   );
      return now_lvl && !was_lvl;
   endfunction

   // edge of the serial clock, sampled in the system clock
   assign sclk_rise = rise_of(ctrl.sclk, state.sclk_q);

   // ==========================================================
   // next-state logic
   // next state: shift, latch, gate drivers
   always_comb
   begin
      next_state        = state;
      next_state.sclk_q = ctrl.sclk;
      if (sclk_rise)
      begin
         next_state.shift = {state.shift[`SILD_MSB-1:0], ctrl.sdata};
      end
      if (ctrl.strobe)
      begin
         next_state.latch = next_state.shift;
      end
      // otherwise latch holds
      next_state.sout = next_state.shift[`SILD_MSB];
      if (ctrl.out_disable)
      begin
         next_state.drive = `SILD_ALL_OFF;
      end
      else
      begin
         next_state.drive = next_state.latch;
      end
   end

   // ==========================================================
   // state register and outputs
   // state register
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state.shift  <= `SILD_ZERO8;
         state.latch  <= `SILD_ZERO8;
         state.drive  <= `SILD_ALL_OFF;
         state.sclk_q <= 1'b0;
         state.sout   <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   // outputs straight from registered state
   assign drive_on   = state.drive;
   assign serial_out = state.sout;
   assign latch_view = state.latch;

   // ==========================================================
   // assertions
   sequence s_rise;
      sclk_rise;
   endsequence

   // a rise with strobe high, strobe still high a cycle on
   sequence s_follow;
      (s_rise and ctrl.strobe) ##1 ctrl.strobe;
   endsequence

   // drivers disabled, then enabled again
   sequence s_reenable;
      ctrl.out_disable ##1 !ctrl.out_disable;
   endsequence

   property p_capture;
      @(posedge clk) disable iff (srst)
      s_rise |=> state.shift[0] == $past(ctrl.sdata);
   endproperty
   a_capture: assert property (p_capture)
      else $error("serial data not captured");

   property p_shift;
      @(posedge clk) disable iff (srst)
      s_rise |=> state.shift[`SILD_MSB:1] == $past(state.shift[`SILD_MSB-1:0]);
   endproperty
   a_shift: assert property (p_shift)
      else $error("stages did not shift");

   property p_noshift;
      @(posedge clk) disable iff (srst)
      !sclk_rise |=> $stable(state.shift);
   endproperty
   a_noshift: assert property (p_noshift)
      else $error("shift without clock rise");

   property p_transparent;
      @(posedge clk) disable iff (srst)
      ctrl.strobe |=> state.latch == state.shift;
   endproperty
   a_transparent: assert property (p_transparent)
      else $error("latch not following register");

   property p_follow;
      @(posedge clk) disable iff (srst)
      s_follow |=> state.latch == state.shift;
   endproperty
   a_follow: assert property (p_follow)
      else $error("latch stopped following");

   property p_hold;
      @(posedge clk) disable iff (srst)
      !ctrl.strobe |=> $stable(state.latch);
   endproperty
   a_hold: assert property (p_hold)
      else $error("latch changed with strobe low");

   property p_off;
      @(posedge clk) disable iff (srst)
      ctrl.out_disable |=> drive_on == `SILD_ALL_OFF;
   endproperty
   a_off: assert property (p_off)
      else $error("drivers on while disabled");

   property p_on;
      @(posedge clk) disable iff (srst)
      !ctrl.out_disable |=> drive_on == state.latch;
   endproperty
   a_on: assert property (p_on)
      else $error("drivers differ from latches");

   property p_chain;
      @(posedge clk) disable iff (srst)
      1'b1 |=> serial_out == state.shift[`SILD_MSB];
   endproperty
   a_chain: assert property (p_chain)
      else $error("serial output not last stage");

   property p_chain_step;
      @(posedge clk) disable iff (srst)
      s_rise |=> serial_out == $past(state.shift[`SILD_MSB-1]);
   endproperty
   a_chain_step: assert property (p_chain_step)
      else $error("serial output missed a shift");

   property p_chain_hold;
      @(posedge clk) disable iff (srst)
      !sclk_rise |=> $stable(serial_out);
   endproperty
   a_chain_hold: assert property (p_chain_hold)
      else $error("serial output moved without clock");

   property p_history;
      @(posedge clk) disable iff (srst)
      1'b1 |=> state.sclk_q == $past(ctrl.sclk);
   endproperty
   a_history: assert property (p_history)
      else $error("serial clock history wrong");

   property p_keep_shift;
      @(posedge clk) disable iff (srst)
      ctrl.out_disable && !sclk_rise |=> $stable(state.shift);
   endproperty
   a_keep_shift: assert property (p_keep_shift)
      else $error("disable disturbed register");

   property p_keep_latch;
      @(posedge clk) disable iff (srst)
      ctrl.out_disable && !ctrl.strobe |=> $stable(state.latch);
   endproperty
   a_keep_latch: assert property (p_keep_latch)
      else $error("disable disturbed latches");

   property p_off_transfer;
      @(posedge clk) disable iff (srst)
      ctrl.out_disable && ctrl.strobe |=>
         state.latch == state.shift && drive_on == `SILD_ALL_OFF;
   endproperty
   a_off_transfer: assert property (p_off_transfer)
      else $error("transfer blocked by disable");

   property p_drive_through;
      @(posedge clk) disable iff (srst)
      !ctrl.out_disable && ctrl.strobe |=> drive_on == state.shift;
   endproperty
   a_drive_through: assert property (p_drive_through)
      else $error("drivers not fed through latches");

   property p_reenable;
      @(posedge clk) disable iff (srst)
      s_reenable |=> drive_on == state.latch;
   endproperty
   a_reenable: assert property (p_reenable)
      else $error("drivers not back after enable");

endmodule

/* File: rtl/sild_pkg.sv */
package sild_pkg;

   // ==========================================================
   // shared types
   typedef logic [7:0] sild_byte_t;

   // serial-side inputs from the controller
   typedef struct packed
   {
      logic       sclk;
      logic       sdata;
      logic       strobe;
      logic       out_disable;
   } sild_ctrl_s;

   // complete state of the block
   typedef struct packed
   {
      sild_byte_t shift;
      sild_byte_t latch;
      sild_byte_t drive;
      logic       sclk_q;
      logic       sout;
   } sild_state_s;

endpackage

/* File: tb/serial_in_latched_output_driver_test.sv */
`timescale 1ns/100ps
`define CHK(n,e,a) begin n_tests++; if ((a) !== (e)) begin \
$display("BAD %s exp %h got %h", n, e, a); n_mismatch++; end end
module serial_in_latched_output_driver_test;
   logic                 clk;
   logic                 srst;
   sild_pkg::sild_ctrl_s ctrl;
   sild_pkg::sild_byte_t drive_on;
   sild_pkg::sild_byte_t latch_view;
   logic                 serial_out;
   int                   n_mismatch = 0;
   int                   n_tests = 0;

   sild_host host (.clk(clk), .ctrl(ctrl));
   sild_driver dut (.clk(clk), .srst(srst), .ctrl(ctrl),
      .drive_on(drive_on), .serial_out(serial_out),
      .latch_view(latch_view));

   // verdict and stop
   task automatic end_of_test();
      if (n_mismatch == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // shift with strobe low, then one strobe pulse
   task automatic t_load();
      host.send(8'hB4);
      `CHK("serial_out", 1'b1, serial_out)
      `CHK("latch_held", 8'h00, latch_view)
      host.set(1'b1, 1'b0);
      host.set(1'b0, 1'b0);
      repeat (2) @(negedge clk);
      `CHK("latch", 8'hB4, latch_view)
      `CHK("drive", 8'hB4, drive_on)
   endtask

   // disabled drivers, transparent latches while shifting
   task automatic t_bypass();
      host.set(1'b0, 1'b1);
      repeat (2) @(negedge clk);
      `CHK("drive_off", 8'h00, drive_on)
      `CHK("latch_kept", 8'hB4, latch_view)
      host.set(1'b1, 1'b1);
      host.send(8'h3C);
      `CHK("transparent", 8'h3C, latch_view)
      `CHK("drive_off2", 8'h00, drive_on)
      `CHK("serial_out2", 1'b0, serial_out)
      host.set(1'b0, 1'b0);
      repeat (2) @(negedge clk);
      `CHK("drive2", 8'h3C, drive_on)
   endtask

   // reset in mid-run, then first byte after release
   task automatic t_reset();
      @(negedge clk) srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      `CHK("drive_rst2", 8'h00, drive_on)
      `CHK("latch_rst2", 8'h00, latch_view)
      `CHK("serial_rst2", 1'b0, serial_out)
      host.send(8'h81);
      `CHK("serial_out3", 1'b1, serial_out)
      host.set(1'b1, 1'b0);
      host.set(1'b0, 1'b0);
      repeat (2) @(negedge clk);
      `CHK("latch3", 8'h81, latch_view)
      `CHK("drive3", 8'h81, drive_on)
   endtask

   // clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // watchdog
   initial
   begin
      #50000;
      n_mismatch++;
      end_of_test();
   end

   // main sequence
   initial
   begin
      srst = 1'b1;
      repeat (8) @(negedge clk);
      srst = 1'b0;
      `CHK("drive_rst", 8'h00, drive_on)
      t_load();
      t_bypass();
      t_reset();
      end_of_test();
   end
endmodule

/* File: tb/sild_host.sv */
`timescale 1ns/100ps
`include "sild_consts.svh"
// ==========================================================
// controller model driving the serial side
module sild_host
(
   // clock
   input  wire logic                 clk,
   // serial controls
   output      sild_pkg::sild_ctrl_s ctrl
);
   // shift a byte msb first, clock high one cycle, low two
   task automatic send(input sild_pkg::sild_byte_t b);
      for (int i = 7; i >= 0; i--)
      begin
         @(negedge clk) ctrl.sdata = b[i];
         @(negedge clk) ctrl.sclk = 1'b1;
         @(negedge clk) ctrl.sclk = 1'b0;
      end
      ctrl.sdata = ~ctrl.sdata; // data inverted from the last bit, not left at it
      repeat (`SILD_STB_GAP_CYC) @(negedge clk);
   endtask

   // strobe and disable levels
   task automatic set(input logic s, input logic d);
      @(negedge clk);
      ctrl.strobe = s;
      ctrl.out_disable = d;
   endtask

   initial ctrl = '0;
endmodule
